// *** core/tbc_pkg.sv ***
// package of constants and types for the buffered cascaded pwm timer
// Function
// - channels 0, 3, 4: register c buffers register a, d buffers b.
// - buffered compare: each match copies buffer into its general register.
// - buffered capture: counter into general register, old value into buffer.
// - channel 1 counter is upper half, channel 2 lower half of 32 bits.
// - cascade clock select: channel 1 counts each channel 2 overflow or underflow.
// - channel 2 underflows only in phase counting; otherwise only overflow cascades.
// - phase counting on channel 1 overrides its clock select, no cascade.
// - upper counter increments on lower overflow, decrements on lower underflow.
// - simultaneous captures store upper half in ch1 a, lower in ch2 a.
// - pwm compare matches drive pin low, high or toggle; duty 0 to 100%.
// - pwm per channel independent; clear-source register defines the period.
// - pwm mode 1 pairs a with b, c with d, driving pins a and c.
// - pwm mode 1: a/c matches use own actions, b/d matches theirs, same pin.
// - pwm mode 1 initial pin level is that set for register a or c.
// - pwm mode 1: equal pair values leave the output unchanged on match.
// - pwm mode 1 gives at most eight output phases over all channels.
// - pwm mode 2: cycle register clears, all pins return to initial level.
// - pwm mode 2: duty equal to cycle leaves that output unchanged.
// - pwm mode 2, offered on channels 1 and 2 only, gives at most two phases.
// - pwm mode 2: the period register drives no output on its pin.
// - a channel counter runs while its start bit is set.
package tbc_pkg;
	// ==========================================================
	// register map, byte addresses: channel block is ch * 0x20
	localparam logic [7:0] TBC_OFS_CTRL = 8'h00;
	localparam logic [7:0] TBC_OFS_IO = 8'h04;
	localparam logic [7:0] TBC_OFS_CNT = 8'h08;
	localparam logic [7:0] TBC_OFS_GRA = 8'h0c;
	localparam logic [7:0] TBC_OFS_GRB = 8'h10;
	localparam logic [7:0] TBC_OFS_GRC = 8'h14;
	localparam logic [7:0] TBC_OFS_GRD = 8'h18;
	localparam logic [7:0] TBC_CH_STRIDE = 8'h20;
	localparam logic [7:0] TBC_ADR_START = 8'ha0;
	// ==========================================================
	// reset values
	localparam logic [15:0] TBC_RST_CNT = 16'h0000;
	localparam logic [15:0] TBC_RST_GR = 16'hffff;
	localparam logic [15:0] TBC_RST_IO = 16'h0000;
	localparam logic [4:0] TBC_RST_START = 5'h00;
	localparam logic [15:0] TBC_CNT_MAX = 16'hffff;
	// ==========================================================
	// clock select codes
	localparam logic [2:0] TBC_CS_INT = 3'h0;
	localparam logic [2:0] TBC_CS_EXT = 3'h1;
	localparam logic [2:0] TBC_CS_CASC = 3'h7;
	// io nibble: bit 3 capture, bit 2 initial level, bits 1:0 action/edge
	localparam int TBC_IO_CAP = 3;
	localparam int TBC_IO_INIT = 2;
	localparam logic [1:0] TBC_ACT_NONE = 2'h0;
	localparam logic [1:0] TBC_ACT_LOW = 2'h1;
	localparam logic [1:0] TBC_ACT_HIGH = 2'h2;
	localparam logic [1:0] TBC_ACT_TOG = 2'h3;
	localparam logic [1:0] TBC_EDGE_RISE = 2'h0;
	localparam logic [1:0] TBC_EDGE_FALL = 2'h1;
	// ==========================================================
	// channel control register layout, bits 9:0
	typedef enum logic [1:0] {
		TBC_MODE_NORMAL,
		TBC_MODE_PWM1,
		TBC_MODE_PWM2,
		TBC_MODE_PHASE
	} tbc_mode_t;
	typedef struct packed {
		logic buf_b;
		logic buf_a;
		tbc_mode_t mode;
		logic [2:0] clear_src;
		logic [2:0] clock_select_field;
	} tbc_ctrl_t;
	localparam tbc_ctrl_t TBC_RST_CTRL = '0;
endpackage : tbc_pkg

// *** core/tbc_timer.sv ***
// five channel timer with buffering, 32-bit cascade and two pwm modes
`timescale 1ns/1ps
module tbc_timer
	import tbc_pkg::*;
#(
	parameter int NUM_CH = 5,
	parameter int CNT_W = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_tick,
	input wire logic [NUM_CH-1:0] phase_up,
	input wire logic [NUM_CH-1:0] phase_down,
	input wire logic [NUM_CH-1:0][3:0] pin_in,
	output logic [NUM_CH-1:0][3:0] pin_out,
	output logic [NUM_CH-1:0][3:0] pin_oe,
	output logic [NUM_CH-1:0] overflow,
	output logic [NUM_CH-1:0] underflow,
	output logic [NUM_CH-1:0] counter_clear
);
	// ==========================================================
	// elaboration checks
	if (NUM_CH != 5 || CNT_W != 16) begin : g_bad_param
		$error("tbc_timer supports only five 16-bit channels");
	end

	// ==========================================================
	// helpers
	// channels that own registers c and d and the buffer function
	function automatic logic full_ch(input int c);
		return (c == 0) || (c == 3) || (c == 4);
	endfunction : full_ch

	// level after a compare action
	function automatic logic apply_act(input logic cur, input logic [1:0] act);
		case (act)
			TBC_ACT_LOW: return 1'b0;
			TBC_ACT_HIGH: return 1'b1;
			TBC_ACT_TOG: return ~cur;
			default: return cur;
		endcase
	endfunction : apply_act

	// byte-lane merge for a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// ==========================================================
	// state
	logic [15:0] cnt_reg [NUM_CH];
	logic [15:0] gr_reg [NUM_CH][4];
	tbc_ctrl_t ctl_reg [NUM_CH];
	logic [15:0] io_reg [NUM_CH];
	logic [NUM_CH-1:0] start_reg;
	logic [NUM_CH-1:0][3:0] pin_reg;
	logic [NUM_CH-1:0][3:0] in_prev_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] rd_mux;

	// ==========================================================
	// bus decode
	wire logic req = wb_cyc_i && wb_stb_i;
	wire logic wr_fire = req && wb_we_i && ack_reg;
	wire logic [2:0] adr_ch = wb_adr_i[7:5];
	wire logic [7:0] adr_ofs = {3'h0, wb_adr_i[4:0]};
	wire logic start_hit = wb_adr_i == TBC_ADR_START;

	// ==========================================================
	// per channel combinational terms
	tbc_mode_t eff_mode [NUM_CH];
	logic [NUM_CH-1:0] up_tick;
	logic [NUM_CH-1:0] dn_tick;
	logic [NUM_CH-1:0][3:0] match;
	logic [NUM_CH-1:0][3:0] capture;
	logic [NUM_CH-1:0] clr;
	logic [NUM_CH-1:0] wr_ctrl;
	logic [NUM_CH-1:0] wr_io;
	logic [NUM_CH-1:0] wr_cnt;
	logic [NUM_CH-1:0][3:0] wr_gr;
	logic [NUM_CH-1:0][3:0] gr_valid;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_comb
		localparam logic [2:0] CH = 3'(c);
		wire logic phase_ok = (c == 1) || (c == 2);
		wire tbc_mode_t rmode = ctl_reg[c].mode;
		wire logic [2:0] cs = ctl_reg[c].clock_select_field;
		wire logic sel_ch = !start_hit && adr_ch == CH;
		// pwm mode 2 and phase counting fall back where not offered
		assign eff_mode[c] = (rmode == TBC_MODE_PWM2 && !phase_ok) ?
			TBC_MODE_NORMAL :
			(rmode == TBC_MODE_PHASE && !phase_ok) ? TBC_MODE_NORMAL : rmode;
		// count sources: phase counting beats cascade and clock select
		assign up_tick[c] = start_reg[c] && (
			(eff_mode[c] == TBC_MODE_PHASE) ? phase_up[c] :
			(c == 1 && cs == TBC_CS_CASC) ? overflow[2] :
			(cs == TBC_CS_EXT) ? ext_tick : 1'b1);
		assign dn_tick[c] = start_reg[c] && (
			(eff_mode[c] == TBC_MODE_PHASE) ? phase_down[c] :
			(c == 1 && cs == TBC_CS_CASC) ? underflow[2] : 1'b0);
		// underflow exists only for a down count: phase counting, or the channel 1 cascade
		assign overflow[c] = up_tick[c] && cnt_reg[c] == TBC_CNT_MAX;
		assign underflow[c] = dn_tick[c] && cnt_reg[c] == 16'h0000;
		// write strobes
		assign wr_ctrl[c] = wr_fire && sel_ch && adr_ofs == TBC_OFS_CTRL;
		assign wr_io[c] = wr_fire && sel_ch && adr_ofs == TBC_OFS_IO;
		assign wr_cnt[c] = wr_fire && sel_ch && adr_ofs == TBC_OFS_CNT;
		for (genvar g = 0; g < 4; g++) begin : g_gr
			localparam logic [7:0] GOFS = 8'(TBC_OFS_GRA + 8'(4 * g));
			wire logic is_cap = io_reg[c][4*g+TBC_IO_CAP];
			wire logic [1:0] edg = io_reg[c][4*g +: 2];
			wire logic rise = pin_in[c][g] && !in_prev_reg[c][g];
			wire logic fall = !pin_in[c][g] && in_prev_reg[c][g];
			assign gr_valid[c][g] = (g < 2) || full_ch(c);
			assign wr_gr[c][g] = wr_fire && sel_ch && adr_ofs == GOFS &&
				gr_valid[c][g];
			// compare match while counting
			assign match[c][g] = gr_valid[c][g] && !is_cap && start_reg[c] &&
				cnt_reg[c] == gr_reg[c][g];
			// capture on the selected edge of the pin input
			assign capture[c][g] = gr_valid[c][g] && is_cap &&
				((edg == TBC_EDGE_RISE) ? rise :
				(edg == TBC_EDGE_FALL) ? fall : (rise || fall));
		end
		// clear source 1..4 picks register a..d as the period
		wire logic [2:0] cs_idx = ctl_reg[c].clear_src - 3'h1;
		assign clr[c] = ctl_reg[c].clear_src != 3'h0 &&
			ctl_reg[c].clear_src <= 3'h4 &&
			(match[c][cs_idx[1:0]] || capture[c][cs_idx[1:0]]);
		assign counter_clear[c] = clr[c];
	end

	// ==========================================================
	// output enables: pin driven when its register compares, except pwm mode 1 pins b, d and the pwm mode 2 period pin
	for (genvar c = 0; c < NUM_CH; c++) begin : g_oe
		for (genvar g = 0; g < 4; g++) begin : g_pin
			wire logic per_pin = ctl_reg[c].clear_src == 3'(g + 1);
			wire logic cmp = gr_valid[c][g] && !io_reg[c][4*g+TBC_IO_CAP];
			assign pin_oe[c][g] = cmp &&
				!(eff_mode[c] == TBC_MODE_PWM1 && g % 2 == 1) &&
				!(eff_mode[c] == TBC_MODE_PWM2 && per_pin);
		end
	end
	assign pin_out = pin_reg;

	// ==========================================================
	// bus answer: one wait cycle, registered read data
	always_ff @(posedge clock) begin
		if (rst) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req && !ack_reg;
			rdat_reg <= rd_mux;
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// read selection, unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (start_hit) begin
			rd_mux = {27'h0, start_reg};
		end else if (adr_ch < 3'(NUM_CH)) begin
			case (adr_ofs)
				TBC_OFS_CTRL: rd_mux = {22'h0, ctl_reg[adr_ch]};
				TBC_OFS_IO: rd_mux = {16'h0, io_reg[adr_ch]};
				TBC_OFS_CNT: rd_mux = {16'h0, cnt_reg[adr_ch]};
				TBC_OFS_GRA: rd_mux = {16'h0, gr_reg[adr_ch][0]};
				TBC_OFS_GRB: rd_mux = {16'h0, gr_reg[adr_ch][1]};
				TBC_OFS_GRC: rd_mux = full_ch(int'(adr_ch)) ?
					{16'h0, gr_reg[adr_ch][2]} : 32'h0000_0000;
				TBC_OFS_GRD: rd_mux = full_ch(int'(adr_ch)) ?
					{16'h0, gr_reg[adr_ch][3]} : 32'h0000_0000;
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// start register
	always_ff @(posedge clock) begin
		if (rst) begin
			start_reg <= TBC_RST_START;
		end else if (wr_fire && start_hit && wb_sel_i[0]) begin
			start_reg <= wb_dat_i[4:0];
		end
	end

	// ==========================================================
	// per channel sequential logic
	for (genvar c = 0; c < NUM_CH; c++) begin : g_seq
		// configuration registers
		always_ff @(posedge clock) begin
			if (rst) begin
				ctl_reg[c] <= TBC_RST_CTRL;
				io_reg[c] <= TBC_RST_IO;
			end else begin
				if (wr_ctrl[c])
					ctl_reg[c] <= tbc_ctrl_t'({wb_sel_i[1] ? wb_dat_i[9:8] :
						ctl_reg[c][9:8], wb_sel_i[0] ? wb_dat_i[7:0] :
						ctl_reg[c][7:0]});
				if (wr_io[c])
					io_reg[c] <= merge16(io_reg[c], wb_dat_i, wb_sel_i);
			end
		end

		// counter: bus write, then clear, then count up or down
		always_ff @(posedge clock) begin
			if (rst) begin
				cnt_reg[c] <= TBC_RST_CNT;
			end else if (wr_cnt[c]) begin
				cnt_reg[c] <= merge16(cnt_reg[c], wb_dat_i, wb_sel_i);
			end else if (clr[c]) begin
				cnt_reg[c] <= TBC_RST_CNT;
			end else if (up_tick[c]) begin
				cnt_reg[c] <= cnt_reg[c] + 16'h0001;
			end else if (dn_tick[c]) begin
				cnt_reg[c] <= cnt_reg[c] - 16'h0001;
			end
		end

		// general registers with buffer transfers
		for (genvar g = 0; g < 4; g++) begin : g_gr
			localparam int PRV = (g + 2) % 4;
			wire logic buf_on = full_ch(c) &&
				((g % 2 == 0) ? ctl_reg[c].buf_a : ctl_reg[c].buf_b);
			always_ff @(posedge clock) begin
				if (rst) begin
					gr_reg[c][g] <= TBC_RST_GR;
					in_prev_reg[c][g] <= 1'b0;
				end else begin
					in_prev_reg[c][g] <= pin_in[c][g];
					if (wr_gr[c][g]) begin
						gr_reg[c][g] <= merge16(gr_reg[c][g], wb_dat_i, wb_sel_i);
					end else if (g < 2 && capture[c][g]) begin
						gr_reg[c][g] <= cnt_reg[c];
					end else if (g < 2 && buf_on && match[c][g]) begin
						gr_reg[c][g] <= gr_reg[c][PRV];
					end else if (g >= 2 && buf_on && capture[c][PRV]) begin
						gr_reg[c][g] <= gr_reg[c][PRV];
					end else if (g >= 2 && !buf_on && capture[c][g]) begin
						gr_reg[c][g] <= cnt_reg[c];
					end
				end
			end
		end

		// pin levels
		wire logic [2:0] per_idx = ctl_reg[c].clear_src - 3'h1;
		for (genvar g = 0; g < 4; g++) begin : g_lvl
			localparam int PAIR = (g % 2 == 0) ? g + 1 : g - 1;
			wire logic [1:0] act = io_reg[c][4*g +: 2];
			wire logic [1:0] act_p = io_reg[c][4*PAIR +: 2];
			wire logic init = io_reg[c][4*g+TBC_IO_INIT];
			wire logic pair_eq = gr_reg[c][g] == gr_reg[c][PAIR];
			wire logic duty_eq = gr_reg[c][g] == gr_reg[c][per_idx[1:0]];
			always_ff @(posedge clock) begin
				if (rst) begin
					pin_reg[c][g] <= 1'b0;
				end else if (!start_reg[c]) begin
					pin_reg[c][g] <= init;
				end else begin
					case (eff_mode[c])
						TBC_MODE_PWM1: begin
							if (g % 2 == 1 || pair_eq)
								pin_reg[c][g] <= pin_reg[c][g];
							else if (match[c][g])
								pin_reg[c][g] <= apply_act(pin_reg[c][g], act);
							else if (match[c][PAIR])
								pin_reg[c][g] <= apply_act(pin_reg[c][g], act_p);
						end
						TBC_MODE_PWM2: begin
							if (clr[c])
								pin_reg[c][g] <= init;
							else if (match[c][g] && !duty_eq)
								pin_reg[c][g] <= apply_act(pin_reg[c][g], act);
						end
						default: begin
							if (match[c][g])
								pin_reg[c][g] <= apply_act(pin_reg[c][g], act);
						end
					endcase
				end
			end
		end
	end
	// pwm mode 1 phases: pins a, c of 0, 3, 4 plus pins a of 1, 2 = 8
	// pwm mode 2 phases: pins of 1, 2 less one period pin each

	// ==========================================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// buffer operation
	buf_cmp_a: assert property (
		match[0][0] && ctl_reg[0].buf_a && !wr_gr[0][0] && !capture[0][0] |=>
		gr_reg[0][0] == $past(gr_reg[0][2]))
		else $error("compare buffer did not reload register a");
	buf_cap_a: assert property (
		capture[3][0] && ctl_reg[3].buf_a && !wr_gr[3][0] && !wr_gr[3][2] |=>
		gr_reg[3][2] == $past(gr_reg[3][0]) && gr_reg[3][0] == $past(cnt_reg[3]))
		else $error("capture buffer did not shift history");

	// cascade
	casc_up_a: assert property (
		overflow[2] && start_reg[1] && eff_mode[1] != TBC_MODE_PHASE &&
		ctl_reg[1].clock_select_field == TBC_CS_CASC &&
		!wr_cnt[1] && !clr[1] && !wr_cnt[2] |=>
		cnt_reg[1] == $past(cnt_reg[1]) + 16'h0001 && cnt_reg[2] == 16'h0000)
		else $error("upper half missed lower overflow");
	casc_dn_a: assert property (
		underflow[2] && up_tick[1] == 1'b0 && dn_tick[1] && !wr_cnt[1] &&
		!clr[1] |=> cnt_reg[1] == $past(cnt_reg[1]) - 16'h0001)
		else $error("upper half missed lower underflow");
	uf_phase_a: assert property (
		underflow[2] |-> eff_mode[2] == TBC_MODE_PHASE)
		else $error("underflow outside phase counting");
	casc_cap_a: assert property (
		capture[1][0] && capture[2][0] && !wr_gr[1][0] && !wr_gr[2][0] |=>
		gr_reg[1][0] == $past(cnt_reg[1]) && gr_reg[2][0] == $past(cnt_reg[2]))
		else $error("cascade capture halves not stored together");

	// start control
	stop_hold_a: assert property (
		!start_reg[0] && !wr_cnt[0] && !clr[0] |=>
		cnt_reg[0] == $past(cnt_reg[0]))
		else $error("stopped counter moved");

	// pwm modes
	period_pin_a: assert property (
		eff_mode[1] == TBC_MODE_PWM2 && ctl_reg[1].clear_src == 3'h2
		|-> !pin_oe[1][1])
		else $error("period register drives its pin");
	pwm2_init_a: assert property (
		eff_mode[1] == TBC_MODE_PWM2 && start_reg[1] && clr[1]
		|=> pin_reg[1][0] == $past(io_reg[1][TBC_IO_INIT]))
		else $error("pin not back at initial level after clear");
	pwm1_pair_a: assert property (
		eff_mode[0] == TBC_MODE_PWM1 |-> !pin_oe[0][1] && !pin_oe[0][3])
		else $error("pwm mode 1 drove pin b or d");
	pwm1_init_a: assert property (
		!start_reg[0] |=> pin_reg[0][0] == $past(io_reg[0][TBC_IO_INIT]))
		else $error("stopped pin not at initial level");
	pwm1_hold_a: assert property (
		eff_mode[0] == TBC_MODE_PWM1 && start_reg[0] &&
		gr_reg[0][0] == gr_reg[0][1] |=> pin_reg[0][0] == $past(pin_reg[0][0]))
		else $error("equal pwm pair changed the pin");
	pwm1_b_act_a: assert property (
		eff_mode[0] == TBC_MODE_PWM1 && start_reg[0] && match[0][1] &&
		!match[0][0] && gr_reg[0][0] != gr_reg[0][1] &&
		io_reg[0][5:4] == TBC_ACT_HIGH |=> pin_reg[0][0])
		else $error("register b match did not set pin a");
	no_pwm2_a: assert property (
		ctl_reg[3].mode == TBC_MODE_PWM2 |-> eff_mode[3] == TBC_MODE_NORMAL)
		else $error("pwm mode 2 accepted on channel 3");

	// main scenarios reached
	cascade_c: cover property (overflow[2] && up_tick[1]);
	pwm1_c: cover property (eff_mode[0] == TBC_MODE_PWM1 && clr[0]);
	buffer_c: cover property (capture[0][0] && ctl_reg[0].buf_a);
	pwm2_c: cover property (eff_mode[1] == TBC_MODE_PWM2 && clr[1]);
	underflow_c: cover property (underflow[2] && dn_tick[1]);
endmodule : tbc_timer

// *** test/tbc_bench.sv ***
// self-checking bench for the buffered cascaded pwm timer
`timescale 1ns/1ps
module timer_buffer_cascade_pwm_bench;
	import tbc_pkg::*;
	logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ext_tick;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [4:0] phase_up, phase_down, overflow, underflow, counter_clear;
	logic [4:0][3:0] pin_in, pin_out, pin_oe;
	int err_count, compares, n_ov;
	// ==========================================================
	// clock and design
	initial clock = 1'b0;
	always #50 clock = ~clock;
	tbc_timer dut (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ext_tick(ext_tick), .phase_up(phase_up),
		.phase_down(phase_down), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .overflow(overflow), .underflow(underflow),
		.counter_clear(counter_clear));
	// ==========================================================
	// compare tasks and verdict
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t reg read %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_cnt
	task automatic summarize();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	// ==========================================================
	// wishbone classic cycle, held until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [7:0] adr,
		input logic [31:0] d);
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		@(posedge clock);
		while (wb_ack_o !== 1'b1) @(posedge clock);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_xfer
	function automatic logic [7:0] ad(input logic [7:0] ch,
		input logic [7:0] ofs);
		return ch * TBC_CH_STRIDE + ofs;
	endfunction : ad
	task automatic wr(input int ch, input logic [7:0] ofs,
		input logic [15:0] d);
		wb_xfer(1'b1, ad(8'(ch), ofs), {16'h0000, d});
	endtask : wr
	task automatic rdchk(input int ch, input logic [7:0] ofs,
		input logic [15:0] exp);
		wb_xfer(1'b0, ad(8'(ch), ofs), 32'h0);
		chk_reg(rd, {16'h0000, exp});
	endtask : rdchk
	task automatic st(input logic [4:0] m);
		wb_xfer(1'b1, TBC_ADR_START, {27'h0, m});
	endtask : st
	function automatic logic [15:0] ctl(input logic [2:0] cs,
		input logic [2:0] clr, input tbc_mode_t m, input logic ba);
		tbc_ctrl_t c;
		c = TBC_RST_CTRL;
		c.clock_select_field = cs;
		c.clear_src = clr;
		c.mode = m;
		c.buf_a = ba;
		return {6'h00, c};
	endfunction : ctl
	// one-cycle pulse on capture pins, flattened channel by pin
	task automatic tick_pin(input logic [19:0] v);
		@(posedge clock);
		pin_in <= v;
		@(posedge clock);
		pin_in <= '0;
	endtask : tick_pin
	// high cycles and period clears over four whole periods of ten
	task automatic pwm_cnt(input int ch, input int p, input int exp);
		int n;
		int nc;
		n = 0;
		nc = 0;
		repeat (12) @(posedge clock);
		repeat (40) begin
			@(posedge clock);
			if (pin_out[ch][p] === 1'b1) n++;
			if (counter_clear[ch] === 1'b1) nc++;
		end
		chk_cnt(n, exp);
		chk_cnt(nc, 4);
	endtask : pwm_cnt
	// ==========================================================
	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clock);
		err_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		summarize();
	end
	// ==========================================================
	// main sequence
	initial begin
		err_count = 0;
		compares = 0;
		rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, ext_tick} = 4'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h3;
		wb_dat_i = 32'h0;
		phase_up = '0;
		phase_down = '0;
		pin_in = '0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rdchk(0, TBC_OFS_GRA, TBC_RST_GR);
		rdchk(0, TBC_OFS_CNT, TBC_RST_CNT);
		wb_xfer(1'b0, 8'hfc, 32'h0);
		chk_reg(rd, 32'h0);
		// buffered compare on channel 0, counter held until started
		wr(0, TBC_OFS_CTRL, ctl(TBC_CS_INT, 3'h0, TBC_MODE_NORMAL, 1'b1));
		wr(0, TBC_OFS_GRA, 16'h0005);
		wr(0, TBC_OFS_GRC, 16'h0009);
		repeat (5) @(posedge clock);
		rdchk(0, TBC_OFS_CNT, 16'h0000);
		st(5'h01);
		repeat (30) @(posedge clock);
		rdchk(0, TBC_OFS_GRA, 16'h0009);
		st(5'h00);
		wb_xfer(1'b0, ad(8'h00, TBC_OFS_CNT), 32'h0);
		chk_reg({31'h0, rd !== 32'h0}, 32'h1);
		// buffered capture on channel 3, two captures in a row
		wr(3, TBC_OFS_CTRL, ctl(TBC_CS_INT, 3'h0, TBC_MODE_NORMAL, 1'b1));
		wr(3, TBC_OFS_IO, 16'h0008);
		wr(3, TBC_OFS_CNT, 16'h0100);
		tick_pin(20'h01000);
		rdchk(3, TBC_OFS_GRA, 16'h0100);
		rdchk(3, TBC_OFS_GRC, 16'hffff);
		wr(3, TBC_OFS_CNT, 16'h0200);
		tick_pin(20'h01000);
		rdchk(3, TBC_OFS_GRA, 16'h0200);
		rdchk(3, TBC_OFS_GRC, 16'h0100);
		// cascade: channel 2 lower half wraps into channel 1
		wr(1, TBC_OFS_CTRL, ctl(TBC_CS_CASC, 3'h0, TBC_MODE_NORMAL, 1'b0));
		wr(2, TBC_OFS_CTRL, ctl(TBC_CS_EXT, 3'h0, TBC_MODE_NORMAL, 1'b0));
		wr(2, TBC_OFS_CNT, 16'hfffe);
		st(5'h06);
		@(posedge clock);
		ext_tick <= 1'b1;
		n_ov = 0;
		repeat (3) begin
			@(posedge clock);
			if (overflow[2] === 1'b1) n_ov++;
		end
		ext_tick <= 1'b0;
		chk_cnt(n_ov, 1);
		rdchk(1, TBC_OFS_CNT, 16'h0001);
		rdchk(2, TBC_OFS_CNT, 16'h0001);
		wr(1, TBC_OFS_IO, 16'h0008);
		wr(2, TBC_OFS_IO, 16'h0008);
		wr(2, TBC_OFS_CNT, 16'h0042);
		tick_pin(20'h00110);
		rdchk(1, TBC_OFS_GRA, 16'h0001);
		rdchk(2, TBC_OFS_GRA, 16'h0042);
		// lower half underflow in phase counting moves the upper down
		wr(2, TBC_OFS_CTRL, ctl(TBC_CS_INT, 3'h0, TBC_MODE_PHASE, 1'b0));
		wr(2, TBC_OFS_CNT, 16'h0000);
		@(posedge clock);
		phase_down <= 5'h04;
		@(posedge clock);
		chk_cnt(int'(underflow[2] === 1'b1), 1);
		phase_down <= 5'h00;
		rdchk(1, TBC_OFS_CNT, 16'h0000);
		rdchk(2, TBC_OFS_CNT, 16'hffff);
		// phase mode on the upper channel overrides the cascade select
		wr(1, TBC_OFS_CTRL, ctl(TBC_CS_CASC, 3'h0, TBC_MODE_PHASE, 1'b0));
		@(posedge clock);
		phase_up <= 5'h04;
		@(posedge clock);
		phase_up <= 5'h00;
		rdchk(1, TBC_OFS_CNT, 16'h0000);
		rdchk(2, TBC_OFS_CNT, 16'h0000);
		st(5'h00);
		// pwm mode 1 on channel 0: period a, duty b
		wr(0, TBC_OFS_CTRL, ctl(TBC_CS_INT, 3'h1, TBC_MODE_PWM1, 1'b0));
		wr(0, TBC_OFS_GRA, 16'h0009);
		wr(0, TBC_OFS_GRB, 16'h0004);
		wr(0, TBC_OFS_IO, 16'h0025);
		wr(0, TBC_OFS_CNT, 16'h0000);
		repeat (2) @(posedge clock);
		chk_cnt(int'(pin_out[0][0] === 1'b1), 1);
		st(5'h01);
		pwm_cnt(0, 0, 20);
		st(5'h00);
		wr(0, TBC_OFS_GRB, 16'h0009);
		wr(0, TBC_OFS_CNT, 16'h0000);
		st(5'h01);
		pwm_cnt(0, 0, 40);
		st(5'h00);
		// pwm mode 2 on channel 1: period b, duty a
		wr(1, TBC_OFS_CTRL, ctl(TBC_CS_INT, 3'h2, TBC_MODE_PWM2, 1'b0));
		wr(1, TBC_OFS_IO, 16'h0002);
		wr(1, TBC_OFS_GRA, 16'h0003);
		wr(1, TBC_OFS_GRB, 16'h0009);
		wr(1, TBC_OFS_CNT, 16'h0000);
		st(5'h02);
		chk_cnt(int'(pin_oe[1][1] === 1'b0), 1);
		pwm_cnt(1, 0, 24);
		st(5'h00);
		wr(1, TBC_OFS_GRA, 16'h0009);
		wr(1, TBC_OFS_CNT, 16'h0000);
		st(5'h02);
		pwm_cnt(1, 0, 0);
		// pwm mode 2 refused on channel 3: plain compare, no return
		wr(3, TBC_OFS_CTRL, ctl(TBC_CS_INT, 3'h2, TBC_MODE_PWM2, 1'b0));
		wr(3, TBC_OFS_IO, 16'h0002);
		wr(3, TBC_OFS_GRA, 16'h0003);
		wr(3, TBC_OFS_GRB, 16'h0009);
		wr(3, TBC_OFS_CNT, 16'h0000);
		st(5'h08);
		pwm_cnt(3, 0, 40);
		summarize();
	end
endmodule : timer_buffer_cascade_pwm_bench
